// ---- logic/dso_map.svh ----
`ifndef DSO_MAP_SVH
`define DSO_MAP_SVH

// Register byte offsets on the AXI4-Lite port.
`define DSO_OFS_SEL_A      8'h00
`define DSO_OFS_SEL_B      8'h04
`define DSO_OFS_START_FREQ 8'h08
`define DSO_OFS_SENS       8'h0C
`define DSO_OFS_FWD_THR    8'h10
`define DSO_OFS_REV_THR    8'h14
`define DSO_OFS_EXT_DISP   8'h18
`define DSO_OFS_STATUS     8'h1C

// Reset values; frequencies are in 0.1 Hz steps, sensitivity in percent.
`define DSO_RST_SEL_A      16'h0000
`define DSO_RST_SEL_B      16'h0063
`define DSO_RST_START_FREQ 16'h0005
`define DSO_RST_SENS       8'h0A
`define DSO_RST_FWD_THR    16'h003C
`define DSO_RST_REV_THR    16'h270F
`define DSO_RST_EXT_DISP   16'h0000

// Setting limits.
`define DSO_SENS_MAX       8'h64
`define DSO_THR_MAX        16'h0FA0
`define DSO_THR_SAME       16'h270F

// Function selection codes and polarity split.
`define DSO_CODE_RUNNING   16'h0000
`define DSO_CODE_REACHED   16'h0001
`define DSO_CODE_THRESHOLD 16'h0004
`define DSO_CODE_READY     16'h000B
`define DSO_CODE_HW_FAULT  16'h005B
`define DSO_CODE_TRIP      16'h0063
`define DSO_CODE_NEG_BASE  16'h0064
`define DSO_CODE_MAX       16'h00C7

// Status register field positions.
`define DSO_STAT_FLAGS_LSB 0
`define DSO_STAT_TERM_LSB  8

// AXI responses.
`define DSO_RESP_OKAY      2'h0
`define DSO_RESP_SLVERR    2'h2

`endif

// ---- logic/dso_pkg.sv ----
package dso_pkg;

  // Drive state sampled from the core, all active high.
  typedef struct packed {
    logic able_to_start;
    logic power_fail;
    logic undervoltage;
    logic output_stop_input;
    logic dc_brake;
    logic tripped;
    logic reverse;
    logic brake_transistor_fault;
    logic earth_fault_at_start;
    logic output_phase_loss_fault;
    logic param_storage_fault;
    logic processor_fault;
    logic inrush_limit_fault;
    logic accel_overcurrent_trip;
    logic earth_fault_as_accel;
  } dso_drive_t;

  typedef struct packed {
    logic frequency_threshold_flag;
    logic hardware_fault_flag;
    logic trip_fault_flag;
    logic reached_frequency_flag;
    logic running_flag;
    logic operation_ready_flag;
  } dso_flags_t;

  typedef struct packed {
    logic [1:0][15:0] sel;
    logic [15:0]      start_freq;
    logic [7:0]       sens;
    logic [15:0]      fwd_thr;
    logic [15:0]      rev_thr;
    logic [15:0]      ext_disp;
    dso_flags_t       flags;
    logic [1:0]       term;
    logic             aw_held;
    logic             w_held;
    logic [7:0]       waddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } dso_state_t;

endpackage

// ---- logic/dso_status_out.sv ----
`timescale 1ns/1ns
`include "dso_map.svh"
// Behaviour
// [R1] Codes 0-99 conduct when function active; codes 100-199 do not conduct.
// [R2] Each terminal decodes its own code, so one function may drive several.
// [R3] Ready flag is on whenever the drive can start, and while running.
// [R4] Running flag on at or above starting frequency; off when stopped or braking.
// [R5] Codes 11/111 carry ready flag, 0/100 carry running flag.
// [R6] Ready drops on power fail, undervoltage, trip or output stop; stays during braking.
// [R7] After reset the running terminal carries the running flag, positive polarity.
// [R8] Fault flag is on whenever the drive has tripped.
// [R9] Relay terminal carries fault flag by default; codes 99/199 route it elsewhere.
// [R10] Hardware fault flag only for the six listed internal or wiring faults.
// [R11] Codes 91/191 carry the hardware fault flag.
// [R12] Earth fault reported as acceleration overcurrent still sets hardware fault.
// [R13] Reached flag when output frequency is within sensitivity band; 0-100 %, default 10.
// [R14] Codes 1/101 carry the reached frequency flag.
// [R15] Threshold flag at or above forward threshold, 0-400 Hz, default 6 Hz.
// [R16] Reverse threshold 9999 means forward threshold in both directions.
// [R17] Codes 4/104 carry the frequency threshold flag.
// [R18] Reached and threshold flags are held off during DC injection braking.
// [R19] Comparisons use output frequency before slip compensation.
// [R20] Sensitivity and thresholds writable only while extended display select is zero.
// [R21] Software should keep fast toggling flags off the relay terminal.
// [R22] Reached when absolute error is at most sensitivity percent of set frequency.
module dso_status_out
  import dso_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Drive state.
  input  wire dso_drive_t  i_drive,
  input  wire logic [15:0] i_out_freq_raw,
  input  wire logic [15:0] i_set_freq,
  // Output terminals: bit 0 running terminal, bit 1 relay contact.
  output logic [1:0]       o_term,
  // AXI4-Lite write address and data.
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  // AXI4-Lite write response.
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  // AXI4-Lite read.
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp
);

  //////////////////////////////////////////////////////////////////////////////

  dso_state_t s_reg;
  dso_state_t s_next;
  dso_flags_t flags_now;
  logic [1:0] term_now;

  // Conduction of one terminal for its selection code.
  function automatic logic term_drive(input logic [15:0] code, input dso_flags_t f);
    logic [15:0] base;
    logic        neg;
    logic        act;
    logic        known;
    neg   = (code >= `DSO_CODE_NEG_BASE);
    base  = neg ? (code - `DSO_CODE_NEG_BASE) : code;
    act   = 1'b0;
    known = (code <= `DSO_CODE_MAX);
    case (base)
      `DSO_CODE_RUNNING:   act = f.running_flag;                   // [R5]
      `DSO_CODE_REACHED:   act = f.reached_frequency_flag;         // [R14]
      `DSO_CODE_THRESHOLD: act = f.frequency_threshold_flag;       // [R17]
      `DSO_CODE_READY:     act = f.operation_ready_flag;           // [R5]
      `DSO_CODE_HW_FAULT:  act = f.hardware_fault_flag;            // [R11]
      `DSO_CODE_TRIP:      act = f.trip_fault_flag;                // [R9]
      default:             known = 1'b0;
    endcase
    // Unknown codes mean no function and leave the terminal open.
    return known & (act ^ neg); // [R1]
  endfunction

  // Byte-lane merge of a write into a narrow register.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = d[7:0];
    end
    if (be[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Status flags.

  logic [15:0] freq_err;
  logic [23:0] err_scaled;
  logic [23:0] band;
  logic [15:0] thr_sel;
  logic        shutoff;

  always_comb begin
    // The raw output frequency is the value ahead of slip compensation.
    freq_err   = (i_out_freq_raw >= i_set_freq) ? (i_out_freq_raw - i_set_freq)
                                                : (i_set_freq - i_out_freq_raw); // [R19]
    err_scaled = {8'h00, freq_err} * 24'h000064;
    band       = {16'h0000, s_reg.sens} * {8'h00, i_set_freq};
    thr_sel    = (i_drive.reverse && (s_reg.rev_thr != `DSO_THR_SAME)) ? s_reg.rev_thr
                                                                       : s_reg.fwd_thr; // [R16]
    shutoff    = i_drive.tripped | i_drive.output_stop_input;

    flags_now.running_flag = (i_out_freq_raw >= s_reg.start_freq)
                           & ~i_drive.dc_brake & ~shutoff;                       // [R4]
    // Running implies ready unless power fail or undervoltage is present, even if the core drops its able-to-start level meanwhile.
    flags_now.operation_ready_flag = (i_drive.able_to_start | flags_now.running_flag) // [R3]
                                   & ~i_drive.power_fail & ~i_drive.undervoltage // [R6]
                                   & ~shutoff;                                   // [R6]
    flags_now.trip_fault_flag = i_drive.tripped;                                 // [R8]
    flags_now.hardware_fault_flag = i_drive.brake_transistor_fault
                                  | i_drive.earth_fault_at_start
                                  | i_drive.output_phase_loss_fault
                                  | i_drive.param_storage_fault
                                  | i_drive.processor_fault
                                  | i_drive.inrush_limit_fault                   // [R10]
                                  | (i_drive.accel_overcurrent_trip & i_drive.earth_fault_as_accel); // [R12]
    flags_now.reached_frequency_flag = (err_scaled <= band) & ~i_drive.dc_brake; // [R13] [R22] [R18]
    flags_now.frequency_threshold_flag = (i_out_freq_raw >= thr_sel)
                                       & ~i_drive.dc_brake;                      // [R15] [R18]
  end

  // Each terminal has its own decoder, so a flag may appear on both.
  for (genvar t = 0; t < 2; t++) begin : g_term
    assign term_now[t] = term_drive(s_reg.sel[t], flags_now); // [R2]
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state: flags, terminals and the AXI4-Lite slave.

  logic        do_write;
  logic        ext_ok;
  logic [15:0] wval;
  logic [7:0]  raddr;
  logic [31:0] rd;
  logic        rd_ok;
  logic        wr_ok;

  always_comb begin
    s_next       = s_reg;
    s_next.flags = flags_now;
    s_next.term  = term_now;

    if (i_awvalid && s_reg.awready) begin
      s_next.aw_held = 1'b1;
      s_next.waddr   = i_awaddr;
    end
    if (i_wvalid && s_reg.wready) begin
      s_next.w_held = 1'b1;
      s_next.wdata  = i_wdata;
      s_next.wstrb  = i_wstrb;
    end

    do_write = s_next.aw_held && s_next.w_held && !s_reg.bvalid;
    // Settings tied to the extended display are frozen while it is nonzero.
    ext_ok   = (s_reg.ext_disp == 16'h0000); // [R20]
    wval     = 16'h0000;
    wr_ok    = 1'b1;
    if (do_write) begin
      s_next.aw_held = 1'b0;
      s_next.w_held  = 1'b0;
      s_next.bvalid  = 1'b1;
      if (s_next.waddr == `DSO_OFS_SEL_A) begin
        s_next.sel[0] = merge16(s_reg.sel[0], s_next.wdata, s_next.wstrb);
      end else if (s_next.waddr == `DSO_OFS_SEL_B) begin
        s_next.sel[1] = merge16(s_reg.sel[1], s_next.wdata, s_next.wstrb);
      end else if (s_next.waddr == `DSO_OFS_START_FREQ) begin
        s_next.start_freq = merge16(s_reg.start_freq, s_next.wdata, s_next.wstrb);
      end else if (s_next.waddr == `DSO_OFS_SENS) begin
        wval = merge16({8'h00, s_reg.sens}, s_next.wdata, s_next.wstrb);
        if (ext_ok && wval <= {8'h00, `DSO_SENS_MAX}) begin
          s_next.sens = wval[7:0]; // [R13] [R20]
        end
      end else if (s_next.waddr == `DSO_OFS_FWD_THR) begin
        wval = merge16(s_reg.fwd_thr, s_next.wdata, s_next.wstrb);
        if (ext_ok && wval <= `DSO_THR_MAX) begin
          s_next.fwd_thr = wval; // [R15] [R20]
        end
      end else if (s_next.waddr == `DSO_OFS_REV_THR) begin
        wval = merge16(s_reg.rev_thr, s_next.wdata, s_next.wstrb);
        if (ext_ok && (wval <= `DSO_THR_MAX || wval == `DSO_THR_SAME)) begin
          s_next.rev_thr = wval; // [R16] [R20]
        end
      end else if (s_next.waddr == `DSO_OFS_EXT_DISP) begin
        s_next.ext_disp = merge16(s_reg.ext_disp, s_next.wdata, s_next.wstrb);
      end else if (s_next.waddr == `DSO_OFS_STATUS) begin
        wr_ok = 1'b1;
      end else begin
        wr_ok = 1'b0;
      end
      s_next.bresp = wr_ok ? `DSO_RESP_OKAY : `DSO_RESP_SLVERR;
    end else if (s_reg.bvalid && i_bready) begin
      s_next.bvalid = 1'b0;
    end

    // Ready is withheld while an item waits or a response is pending.
    s_next.awready = !s_next.aw_held && !s_next.bvalid;
    s_next.wready  = !s_next.w_held && !s_next.bvalid;

    raddr = i_araddr;
    rd    = 32'h0000_0000;
    rd_ok = 1'b1;
    if (raddr == `DSO_OFS_SEL_A) begin
      rd = {16'h0000, s_reg.sel[0]};
    end else if (raddr == `DSO_OFS_SEL_B) begin
      rd = {16'h0000, s_reg.sel[1]};
    end else if (raddr == `DSO_OFS_START_FREQ) begin
      rd = {16'h0000, s_reg.start_freq};
    end else if (raddr == `DSO_OFS_SENS) begin
      rd = {24'h000000, s_reg.sens};
    end else if (raddr == `DSO_OFS_FWD_THR) begin
      rd = {16'h0000, s_reg.fwd_thr};
    end else if (raddr == `DSO_OFS_REV_THR) begin
      rd = {16'h0000, s_reg.rev_thr};
    end else if (raddr == `DSO_OFS_EXT_DISP) begin
      rd = {16'h0000, s_reg.ext_disp};
    end else if (raddr == `DSO_OFS_STATUS) begin
      rd[`DSO_STAT_FLAGS_LSB +: 6] = s_reg.flags;
      rd[`DSO_STAT_TERM_LSB +: 2]  = s_reg.term;
    end else begin
      rd_ok = 1'b0;
    end

    if (i_arvalid && s_reg.arready) begin
      s_next.arready = 1'b0;
      s_next.rvalid  = 1'b1;
      s_next.rdata   = rd;
      s_next.rresp   = rd_ok ? `DSO_RESP_OKAY : `DSO_RESP_SLVERR;
    end else if (s_reg.rvalid && i_rready) begin
      s_next.rvalid  = 1'b0;
      s_next.arready = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s_reg            <= '0;
      s_reg.sel[0]     <= `DSO_RST_SEL_A; // [R7]
      s_reg.sel[1]     <= `DSO_RST_SEL_B; // [R9]
      s_reg.start_freq <= `DSO_RST_START_FREQ;
      s_reg.sens       <= `DSO_RST_SENS;
      s_reg.fwd_thr    <= `DSO_RST_FWD_THR;
      s_reg.rev_thr    <= `DSO_RST_REV_THR;
      s_reg.ext_disp   <= `DSO_RST_EXT_DISP;
      s_reg.awready    <= 1'b1;
      s_reg.wready     <= 1'b1;
      s_reg.arready    <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_term    = s_reg.term;
  assign o_awready = s_reg.awready;
  assign o_wready  = s_reg.wready;
  assign o_bvalid  = s_reg.bvalid;
  assign o_bresp   = s_reg.bresp;
  assign o_arready = s_reg.arready;
  assign o_rvalid  = s_reg.rvalid;
  assign o_rdata   = s_reg.rdata;
  assign o_rresp   = s_reg.rresp;

endmodule

// ---- tb/dso_status_out_props.sv ----
`timescale 1ns/1ns
`include "dso_map.svh"
module dso_status_out_props
  import dso_pkg::*;
(
  // Clock, reset and drive state.
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire dso_drive_t  i_drive,
  input wire logic [15:0] i_out_freq_raw,
  input wire logic [15:0] i_set_freq,
  // Terminals and register bus.
  input wire logic [1:0]  o_term,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic [7:0]  i_awaddr,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0]  i_wstrb,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [1:0]  o_bresp,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [7:0]  i_araddr,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp
);
  // The settings are not visible here, so terminal checks hold only until the first write address below the status offset is taken.
  logic cfg_default_reg;
  logic run_cond;
  logic hw_cond;
  logic stop_cond;
  assign run_cond = i_out_freq_raw >= `DSO_RST_START_FREQ && !i_drive.dc_brake && !i_drive.tripped
                    && !i_drive.output_stop_input;
  assign hw_cond = i_drive.brake_transistor_fault | i_drive.earth_fault_at_start | i_drive.output_phase_loss_fault
                   | i_drive.param_storage_fault | i_drive.processor_fault | i_drive.inrush_limit_fault
                   | (i_drive.accel_overcurrent_trip & i_drive.earth_fault_as_accel);
  assign stop_cond = i_drive.power_fail | i_drive.undervoltage | i_drive.tripped | i_drive.output_stop_input;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cfg_default_reg <= 1'b1;
    end else if (i_awvalid && o_awready && i_awaddr < `DSO_OFS_STATUS) begin
      cfg_default_reg <= 1'b0;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_quiet_cfg;
    cfg_default_reg && !(i_awvalid && o_awready && i_awaddr < `DSO_OFS_STATUS);
  endsequence
  sequence s_stat_rd;
    i_arvalid && o_arready && i_araddr == `DSO_OFS_STATUS && !$past(i_rst);
  endsequence
  sequence s_wr_both;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  AST_RELAY_TRIP: assert property (s_quiet_cfg |=> o_term[1] == $past(i_drive.tripped))
    else $error("Relay terminal differs from the trip state.");
  AST_RUN_TERM: assert property (s_quiet_cfg |=> o_term[0] == $past(run_cond))
    else $error("Running terminal differs from the running state.");
  AST_STAT_TERM: assert property (s_stat_rd |=> o_rdata[9:8] == $past(o_term))
    else $error("Status terminal bits differ from the terminals.");
  AST_STAT_TRIP: assert property (s_stat_rd |=> o_rdata[3] == $past(i_drive.tripped, 2))
    else $error("Status trip bit is wrong.");
  AST_STAT_HW: assert property (s_stat_rd |=> o_rdata[4] == $past(hw_cond, 2))
    else $error("Status hardware fault bit is wrong.");
  AST_STAT_BRAKE: assert property (s_stat_rd and $past(i_drive.dc_brake) |=> !o_rdata[5] && !o_rdata[2])
    else $error("Frequency flags are on while braking.");
  AST_STAT_READY: assert property (s_stat_rd and $past(stop_cond)
                                   |=> !o_rdata[0]
                                       && !(o_rdata[1] && $past(i_drive.tripped || i_drive.output_stop_input, 2)))
    else $error("Ready or running flag is on during shutoff.");
  AST_WR_ANSWER: assert property (s_wr_both |=> o_bvalid && !o_awready && !o_wready)
    else $error("Write response missing.");
  AST_RD_ANSWER: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
    else $error("Read response missing.");
  AST_B_DONE: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("Write response held too long.");
endmodule
bind dso_status_out dso_status_out_props u_props (.*);

// ---- tb/dso_term_reader.sv ----
`timescale 1ns/1ns
module dso_term_reader (
  // Clock and reset.
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // Terminal levels.
  input  wire logic [1:0] i_term,
  // Latched levels and relay activity.
  output logic [1:0]      o_level,
  output logic [15:0]     o_relay_toggles
);
  // Relay chatter is counted because every change wears the contact.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_level         <= 2'h0;
      o_relay_toggles <= 16'h0000;
    end else begin
      o_level         <= i_term;
      o_relay_toggles <= o_relay_toggles + {15'h0000, i_term[1] ^ o_level[1]};
    end
  end
endmodule

// ---- tb/test_dso_status_out.sv ----
`timescale 1ns/1ns
`include "dso_map.svh"
module test_dso_status_out;
  import dso_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  dso_drive_t  drive = 15'h0000;
  logic [15:0] outf = 16'h0000;
  logic [15:0] setf = 16'h0000;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [1:0]  term, bresp, rresp, level;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata;
  logic [15:0] toggles;
  logic [15:0] m_sel [2];
  logic [15:0] m_start, m_fwd, m_rev;
  logic [7:0]  m_sens;
  int          errors = 0;
  int          cmp_count = 0;
  always #20 clk = ~clk;
  dso_status_out u_dut (
    .i_core_clk(clk), .i_rst(rst), .i_drive(drive), .i_out_freq_raw(outf), .i_set_freq(setf), .o_term(term),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp));
  dso_term_reader u_reader (.i_core_clk(clk), .i_rst(rst), .i_term(term), .o_level(level), .o_relay_toggles(toggles));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic at, wt, bt;
    logic [1:0] r;
    int n;
    n = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      at = awvalid && awready;
      wt = wvalid && wready;
      bt = bvalid;
      r = bresp;
      n++;
      @(posedge clk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
    end while (!bt && n < 50);
    bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic t, v;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      t = arvalid && arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      n++;
      @(posedge clk);
      if (t) arvalid <= 1'b0;
    end while (!v && n < 50);
    rready <= 1'b0;
    chk("rdata", d, e);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] exp_flags(input dso_drive_t d, input logic [15:0] o, input logic [15:0] s);
    logic run;
    logic [15:0] lim;
    logic [31:0] diff;
    run = o >= m_start && !d.dc_brake && !d.tripped && !d.output_stop_input;
    lim = (d.reverse && m_rev != `DSO_THR_SAME) ? m_rev : m_fwd;
    diff = (o > s) ? 32'(o - s) : 32'(s - o);
    exp_flags[0] = (d.able_to_start | run) & !(d.power_fail | d.undervoltage | d.tripped | d.output_stop_input);
    exp_flags[1] = run;
    exp_flags[3] = d.tripped;
    exp_flags[2] = !d.dc_brake && diff * 32'h64 <= 32'(m_sens) * 32'(s);
    exp_flags[4] = |{d[7:2], d.accel_overcurrent_trip & d.earth_fault_as_accel};
    exp_flags[5] = !d.dc_brake && o >= lim;
  endfunction
  function automatic logic exp_term(input logic [15:0] c, input logic [5:0] f);
    logic [15:0] b;
    logic v;
    b = (c >= `DSO_CODE_NEG_BASE) ? c - `DSO_CODE_NEG_BASE : c;
    case (b)
      `DSO_CODE_RUNNING:   v = f[1];
      `DSO_CODE_REACHED:   v = f[2];
      `DSO_CODE_THRESHOLD: v = f[5];
      `DSO_CODE_READY:     v = f[0];
      `DSO_CODE_HW_FAULT:  v = f[4];
      `DSO_CODE_TRIP:      v = f[3];
      default:             return 1'b0;
    endcase
    return (c >= `DSO_CODE_NEG_BASE) ? !v : v;
  endfunction
  task automatic apply(input dso_drive_t d, input logic [15:0] o, input logic [15:0] s);
    logic [5:0] f;
    logic [1:0] t;
    f = exp_flags(d, o, s);
    t = {exp_term(m_sel[1], f), exp_term(m_sel[0], f)};
    @(posedge clk);
    drive <= d;
    outf <= o;
    setf <= s;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("terminals", {30'h0, level}, {30'h0, t});
    rd(`DSO_OFS_STATUS, {22'h0, t, 2'h0, f}, `DSO_RESP_OKAY);
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  logic [31:0] rst_tab [7] = '{32'h0, 32'h63, 32'h5, 32'hA, 32'h3C, 32'h270F, 32'h0};
  logic [14:0] cd [12] = '{15'h4000, 15'h4000, 15'h4000, 15'h4000, 15'h4000, 15'h4000, 15'h4400, 15'h4002,
                           15'h4203, 15'h2000, 15'h4908, 15'h0000};
  logic [15:0] co [12] = '{16'h4, 16'h5, 16'h6E, 16'h6F, 16'h5A, 16'h3B, 16'h3C, 16'h3C, 16'h3C, 16'h64, 16'h3C, 16'h64};
  logic [15:0] cs [12] = '{16'h64, 16'h64, 16'h64, 16'h64, 16'h59, 16'h3B, 16'h3C, 16'h64, 16'h64, 16'h64, 16'h3C, 16'h64};
  logic [15:0] codes [13] = '{16'h0, 16'h1, 16'h4, 16'hB, 16'h5B, 16'h63, 16'h64, 16'h65, 16'h68, 16'h6F, 16'hBF,
                              16'hC7, 16'h32};
  initial begin
    logic [15:0] s;
    void'($urandom(75608));
    m_sel[0] = `DSO_RST_SEL_A;
    m_sel[1] = `DSO_RST_SEL_B;
    m_start = `DSO_RST_START_FREQ;
    m_sens = `DSO_RST_SENS;
    m_fwd = `DSO_RST_FWD_THR;
    m_rev = `DSO_RST_REV_THR;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd(8'(i * 4), rst_tab[i], `DSO_RESP_OKAY);
    rd(8'h20, 32'h0, `DSO_RESP_SLVERR);
    wr(8'h20, 32'h1, `DSO_RESP_SLVERR);
    wr(`DSO_OFS_STATUS, 32'hFFFF, `DSO_RESP_OKAY);
    for (int i = 0; i < 12; i++) apply(cd[i], co[i], cs[i]);
    // Settings are locked while the extended display select is nonzero.
    wr(`DSO_OFS_EXT_DISP, 32'h1, `DSO_RESP_OKAY);
    wr(`DSO_OFS_SENS, 32'h32, `DSO_RESP_OKAY);
    wr(`DSO_OFS_FWD_THR, 32'h10, `DSO_RESP_OKAY);
    rd(`DSO_OFS_SENS, 32'hA, `DSO_RESP_OKAY);
    rd(`DSO_OFS_FWD_THR, 32'h3C, `DSO_RESP_OKAY);
    wr(`DSO_OFS_EXT_DISP, 32'h0, `DSO_RESP_OKAY);
    wr(`DSO_OFS_SENS, 32'h65, `DSO_RESP_OKAY);
    wr(`DSO_OFS_FWD_THR, 32'hFA1, `DSO_RESP_OKAY);
    rd(`DSO_OFS_SENS, 32'hA, `DSO_RESP_OKAY);
    rd(`DSO_OFS_FWD_THR, 32'h3C, `DSO_RESP_OKAY);
    for (int i = 0; i < 13; i++) begin
      m_sel[0] = codes[i];
      m_sel[1] = codes[i];
      m_sens = 8'($urandom_range(32'h0, 32'h64));
      m_start = 16'($urandom_range(32'h0, 32'h32));
      m_fwd = 16'($urandom_range(32'h0, 32'h258));
      m_rev = $urandom_range(32'h0, 32'h1) ? `DSO_THR_SAME : 16'($urandom_range(32'h0, 32'h258));
      wr(`DSO_OFS_SEL_A, {16'h0, m_sel[0]}, `DSO_RESP_OKAY);
      wr(`DSO_OFS_SEL_B, {16'h0, m_sel[1]}, `DSO_RESP_OKAY);
      wr(`DSO_OFS_SENS, {24'h0, m_sens}, `DSO_RESP_OKAY);
      wr(`DSO_OFS_START_FREQ, {16'h0, m_start}, `DSO_RESP_OKAY);
      wr(`DSO_OFS_FWD_THR, {16'h0, m_fwd}, `DSO_RESP_OKAY);
      wr(`DSO_OFS_REV_THR, {16'h0, m_rev}, `DSO_RESP_OKAY);
      repeat (8) begin
        s = 16'($urandom_range(32'h0, 32'h258));
        apply(15'($urandom & $urandom), 16'($urandom_range(32'h0, 32'h3C)) + s, s);
      end
    end
    wrap_up();
  end
  // The full run needs about a thousand cycles; the limit leaves wide margin.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule
